// File: shared/pacs_pkg.sv
// Constants and carrier types for the PHY auxiliary control/status bank
// How it works
// R1: Next-page ack-2 bit 12, writable, reset 0
// R2: Next-page bit 11 reads live toggle value
// R3: Next-page bits 10..0 writable message, reset 1
// R4: Partner next page read-only, reset 0
// R5: Control bit 13 turns transmitter off
// R6: Control bit 10 bypasses 4B/5B coding
// R7: Control bit 9 disables scrambler and descrambler
// R8: Control bit 8 skips NRZ/NRZI conversion
// R9: Host writes zero to reserved control bits
// R10: Status bits 9, 8 show lock, link
// R11: False carrier, bad delimiter latch until read
// R12: Receive, transmit errors latch until read
// R13: Lock, three-level code errors latch until read
// R14: Receive error packet counter, clears on read
// R15: False carrier counter, clears on read
// R16: Aux bit 15 disables jabber protection
// R17: Aux bit 14 disables link integrity test
// R18: Aux bits 7..6 pick squelch, never 11
// R19: Counters saturate; read-clear keeps same-cycle event
// R20: Event during clearing read stays set
package pacs_pkg;

   // Register indices; byte address is four times the index
   localparam logic [3:0] IDX_NP_TX = 4'h7;
   localparam logic [3:0] IDX_LP_RX = 4'h8;
   localparam logic [3:0] IDX_CTL   = 4'h9;
   localparam logic [3:0] IDX_STAT  = 4'hA;
   localparam logic [3:0] IDX_RXEC  = 4'hB;
   localparam logic [3:0] IDX_FCC   = 4'hC;
   localparam logic [3:0] IDX_ACS   = 4'hD;
   localparam logic [3:0] IDX_NONE  = 4'hF;

   // Field positions
   localparam int NP_NEXT  = 15;
   localparam int NP_MSGPG = 13;
   localparam int NP_ACK2  = 12;
   localparam int NP_TOG   = 11;
   localparam int CT_TXOFF = 13;
   localparam int CT_4B5B  = 10;
   localparam int CT_SCR   = 9;
   localparam int CT_NRZI  = 8;
   localparam int ST_LOCK  = 9;
   localparam int ST_LINK  = 8;
   localparam int ST_EV_W  = 6;
   localparam int AC_JAB   = 15;
   localparam int AC_LINK  = 14;
   localparam int AC_SQ    = 6;
   localparam int AC_ANI   = 3;

   // Values after reset and masks
   localparam logic [15:0] NP_RST    = 16'h2001;
   localparam logic [15:0] NP_WMASK  = 16'hB7FF;
   localparam logic [15:0] LP_MASK   = 16'hBFFF;
   localparam logic [1:0]  SQ_NORMAL = 2'h0;
   localparam logic [1:0]  SQ_BANNED = 2'h3;
   localparam logic [1:0]  RESP_OKAY = 2'h0;
   localparam logic [1:0]  RESP_SLV  = 2'h2;

   // Latched error events, packed to match status bits 5..0
   typedef struct packed {
      logic false_carrier_seen;
      logic stream_end_error_seen;
      logic receive_error_seen;
      logic transmit_error_seen;
      logic lock_error_seen;
      logic three_level_code_error_seen;
   } pacs_err_t;

   // Live levels and counter pulses from the line side
   typedef struct packed {
      logic descrambler_locked;
      logic fast_link_pass;
      logic autoneg_active_flag;
      logic tx_toggle;
      logic rx_err_packet;
      logic false_carrier_sense;
   } pacs_line_t;

   // Control levels steering the datapath
   typedef struct packed {
      logic       transmitter_off;
      logic       block_code_bypass;
      logic       scrambler_off;
      logic       line_inversion_off;
      logic       jabber_off;
      logic       link_test_off;
      logic [1:0] squelch_select;
   } pacs_ctrl_t;

endpackage

// File: rtl/pacs_regs.sv
// AXI4-Lite register bank for the PHY auxiliary control/status registers
`timescale 1ns/1ps
`default_nettype none
module pacs_regs
   import pacs_pkg::*;
#(
   parameter int AW    = 8,
   parameter int CNT_W = 8
)(
   input  wire logic             aclk,
   input  wire logic             aresetn,
   input  wire logic [AW-1:0]    awaddr,
   input  wire logic             awvalid,
   output var  logic             awready,
   input  wire logic [31:0]      wdata,
   input  wire logic [3:0]       wstrb,
   input  wire logic             wvalid,
   output var  logic             wready,
   output var  logic [1:0]       bresp,
   output var  logic             bvalid,
   input  wire logic             bready,
   input  wire logic [AW-1:0]    araddr,
   input  wire logic             arvalid,
   output var  logic             arready,
   output var  logic [31:0]      rdata,
   output var  logic [1:0]       rresp,
   output var  logic             rvalid,
   input  wire logic             rready,
   input  wire pacs_err_t        err_i,
   input  wire pacs_line_t       line_i,
   input  wire logic [15:0]      partner_page_i,
   output var  pacs_ctrl_t       ctrl_o,
   output var  logic [15:0]      np_page_o
);

   ////////////////////////////////////////////////////////////////////////
   // Elaboration checks
   if (AW < 6)
   begin : g_aw_chk
      $error("AW too small for the register map");
   end
   if (CNT_W < 1 || CNT_W > 8)
   begin : g_cnt_chk
      $error("CNT_W must lie in 1..8");
   end

   // Word index of an address, IDX_NONE when outside the map
   function automatic logic [3:0] reg_sel(input logic [AW-1:0] a);
      logic [3:0] i;
      i = a[5:2];
      if (a[AW-1:6] != '0 || a[1:0] != 2'h0)
         i = IDX_NONE;
      else if (i < IDX_NP_TX || i > IDX_ACS)
         i = IDX_NONE;
      return i;
   endfunction

   // Byte-lane merge of a 16-bit register
   function automatic logic [15:0] merge(input logic [15:0] old,
                                         input logic [15:0] nw,
                                         input logic [1:0]  st);
      logic [15:0] r;
      r = old;
      if (st[0])
         r[7:0] = nw[7:0];
      if (st[1])
         r[15:8] = nw[15:8];
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Bus handshake state
   logic              awready_q;
   logic              wready_q;
   logic              bvalid_q;
   logic [1:0]        bresp_q;
   logic              arready_q;
   logic              rvalid_q;
   logic [1:0]        rresp_q;
   logic [31:0]       rdata_q;
   logic [15:0]       np_q;
   pacs_ctrl_t        ctrl_q;
   logic [ST_EV_W-1:0] stat_q;
   logic [CNT_W-1:0]  cnt_q [2];
   logic [15:0]       rd_val;
   logic              rd_ok;
   logic [3:0]        wr_sel;
   logic [3:0]        rd_sel;
   logic              wr_go;
   logic              wr_hs;
   logic              rd_go;
   logic              rd_hs;
   logic [15:0]       wd;
   logic [1:0]        ws;
   logic [15:0]       wm;
   logic              clr_stat;
   logic [1:0]        cnt_ev;
   logic [1:0]        cnt_clr;

   assign wr_sel = reg_sel(awaddr);
   assign rd_sel = reg_sel(araddr);
   assign wd     = wdata[15:0];
   assign ws     = wstrb[1:0];

   // Both write channels are taken together, one write at a time
   assign wr_go = awvalid & wvalid & ~awready_q & ~bvalid_q;
   assign wr_hs = awvalid & awready_q & wvalid & wready_q;
   assign rd_go = arvalid & ~arready_q & ~rvalid_q;
   assign rd_hs = arvalid & arready_q;

   // Ready pulses for one cycle only
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         awready_q <= 1'b0;
         wready_q  <= 1'b0;
         arready_q <= 1'b0;
      end
      else
      begin
         awready_q <= wr_go;
         wready_q  <= wr_go;
         arready_q <= rd_go;
      end
   end

   // Write response, held until bready
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         bvalid_q <= 1'b0;
         bresp_q  <= RESP_OKAY;
      end
      else if (wr_hs)
      begin
         bvalid_q <= 1'b1;
         bresp_q  <= (wr_sel == IDX_NONE) ? RESP_SLV : RESP_OKAY;
      end
      else if (bready)
         bvalid_q <= 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////
   // Local next page; toggle bit is never stored, read live
   assign wm = merge(np_q, wd, ws);

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         np_q <= NP_RST;                             // [R1] [R3]
      else if (wr_hs && wr_sel == IDX_NP_TX)
         np_q <= wm & NP_WMASK;                      // [R1] [R3]
   end

   // Control bits; reserved bits are dropped on write
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ctrl_q.transmitter_off    <= 1'b0;
         ctrl_q.block_code_bypass  <= 1'b0;
         ctrl_q.scrambler_off      <= 1'b0;
         ctrl_q.line_inversion_off <= 1'b0;
      end
      else if (wr_hs && wr_sel == IDX_CTL && ws[1])
      begin
         ctrl_q.transmitter_off    <= wd[CT_TXOFF];  // [R5]
         ctrl_q.block_code_bypass  <= wd[CT_4B5B];   // [R6]
         ctrl_q.scrambler_off      <= wd[CT_SCR];    // [R7]
         ctrl_q.line_inversion_off <= wd[CT_NRZI];   // [R8]
      end
   end

   // Auxiliary control; a write of the banned squelch code is ignored
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ctrl_q.jabber_off     <= 1'b0;
         ctrl_q.link_test_off  <= 1'b0;
         ctrl_q.squelch_select <= SQ_NORMAL;
      end
      else if (wr_hs && wr_sel == IDX_ACS)
      begin
         if (ws[1])
         begin
            ctrl_q.jabber_off    <= wd[AC_JAB];      // [R16]
            ctrl_q.link_test_off <= wd[AC_LINK];     // [R17]
         end
         if (ws[0] && wd[AC_SQ+1:AC_SQ] != SQ_BANNED)
            ctrl_q.squelch_select <= wd[AC_SQ+1:AC_SQ]; // [R18]
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Sticky error bits; a new event outweighs the read clear
   assign clr_stat = rd_hs && rd_sel == IDX_STAT;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         stat_q <= '0;
      else
         stat_q <= (clr_stat ? '0 : stat_q) | err_i; // [R11] [R12] [R13] [R20]
   end

   // Event counters, saturating and cleared on read
   assign cnt_ev  = {line_i.false_carrier_sense, line_i.rx_err_packet};
   assign cnt_clr = {rd_hs && rd_sel == IDX_FCC, rd_hs && rd_sel == IDX_RXEC};

   for (genvar k = 0; k < 2; k++)
   begin : g_cnt
      always_ff @(posedge aclk)
      begin
         if (!aresetn)
            cnt_q[k] <= '0;                          // [R14] [R15]
         else if (cnt_clr[k])
            cnt_q[k] <= CNT_W'(cnt_ev[k]);           // [R19]
         else if (cnt_ev[k] && cnt_q[k] != '1)
            cnt_q[k] <= cnt_q[k] + 1'b1;             // [R14] [R15] [R19]
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read multiplexer; reserved bits read as zero
   always_comb
   begin
      rd_val = 16'h0000;
      rd_ok  = 1'b1;
      case (rd_sel)
         IDX_NP_TX:
         begin
            rd_val         = np_q;
            rd_val[NP_TOG] = line_i.tx_toggle;       // [R2]
         end
         IDX_LP_RX:
            rd_val = partner_page_i & LP_MASK;       // [R4]
         IDX_CTL:
         begin
            rd_val[CT_TXOFF] = ctrl_q.transmitter_off;
            rd_val[CT_4B5B]  = ctrl_q.block_code_bypass;
            rd_val[CT_SCR]   = ctrl_q.scrambler_off;
            rd_val[CT_NRZI]  = ctrl_q.line_inversion_off;
         end
         IDX_STAT:
         begin
            rd_val[ST_LOCK]         = line_i.descrambler_locked; // [R10]
            rd_val[ST_LINK]         = line_i.fast_link_pass;     // [R10]
            rd_val[ST_EV_W-1:0]     = stat_q;
         end
         IDX_RXEC:
            rd_val[CNT_W-1:0] = cnt_q[0];
         IDX_FCC:
            rd_val[CNT_W-1:0] = cnt_q[1];
         IDX_ACS:
         begin
            rd_val[AC_JAB]          = ctrl_q.jabber_off;
            rd_val[AC_LINK]         = ctrl_q.link_test_off;
            rd_val[AC_SQ+1:AC_SQ]   = ctrl_q.squelch_select;
            rd_val[AC_ANI]          = line_i.autoneg_active_flag;
         end
         default:
            rd_ok = 1'b0;
      endcase
   end

   // Read data captured at the address handshake, held until rready
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rvalid_q <= 1'b0;
         rresp_q  <= RESP_OKAY;
         rdata_q  <= 32'h0000_0000;
      end
      else if (rd_hs)
      begin
         rvalid_q <= 1'b1;
         rresp_q  <= rd_ok ? RESP_OKAY : RESP_SLV;
         rdata_q  <= {16'h0000, rd_val};
      end
      else if (rready)
         rvalid_q <= 1'b0;
   end

   // Outputs straight from flip-flops
   assign awready   = awready_q;
   assign wready    = wready_q;
   assign bvalid    = bvalid_q;
   assign bresp     = bresp_q;
   assign arready   = arready_q;
   assign rvalid    = rvalid_q;
   assign rresp     = rresp_q;
   assign rdata     = rdata_q;
   assign ctrl_o    = ctrl_q;
   assign np_page_o = np_q;

   ////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // Register contents and read side effects
   a_ack2_write: assert property (wr_hs && wr_sel == IDX_NP_TX && ws[1] // [R1]
      |=> np_page_o[NP_ACK2] == $past(wd[NP_ACK2]))
      else $error("ack-2 bit missed its write");
   a_toggle_live: assert property (rd_hs && rd_sel == IDX_NP_TX // [R2]
      |=> rdata[NP_TOG] == $past(line_i.tx_toggle) && !np_page_o[NP_TOG])
      else $error("toggle bit not live");
   a_msg_write: assert property (wr_hs && wr_sel == IDX_NP_TX && ws == 2'h3 // [R3]
      |=> np_page_o[10:0] == $past(wd[10:0]))
      else $error("message field missed its write");
   a_np_fixed: assert property ((np_page_o & ~NP_WMASK) == 16'h0000) // [R1] [R3]
      else $error("read-only next-page bit stored");
   a_partner_read: assert property (rd_hs && rd_sel == IDX_LP_RX // [R4]
      |=> rdata[15:0] == ($past(partner_page_i) & LP_MASK))
      else $error("partner page read wrong");
   a_code_ctrl: assert property (wr_hs && wr_sel == IDX_CTL && ws[1] // [R5] [R6] [R7] [R8]
      |=> {ctrl_o.transmitter_off, ctrl_o.block_code_bypass, ctrl_o.scrambler_off,
           ctrl_o.line_inversion_off} == $past({wd[13], wd[10], wd[9], wd[8]}))
      else $error("datapath control missed its write");
   a_ctrl_lane0: assert property (wr_hs && wr_sel == IDX_CTL && !ws[1] // [R5] [R6] [R7] [R8]
      |=> $stable(ctrl_o))
      else $error("control changed without its byte lane");
   a_stat_live: assert property (rd_hs && rd_sel == IDX_STAT // [R10]
      |=> rdata[9:8] == $past({line_i.descrambler_locked, line_i.fast_link_pass}))
      else $error("live status read wrong");
   a_event_stick: assert property (err_i != '0 // [R11] [R12] [R13] [R20]
      |=> (stat_q & $past(err_i)) == $past(err_i) ##1 (stat_q & $past(err_i, 2)) == $past(err_i, 2)
          || $past(clr_stat))
      else $error("error event not latched");
   a_read_clears: assert property (clr_stat && err_i == '0 // [R11] [R12] [R13]
      |=> stat_q == '0 && rdata[5:0] == $past(stat_q))
      else $error("status read did not clear");
   a_cnt_sat: assert property (cnt_ev[0] && !cnt_clr[0] && cnt_q[0] == '1 // [R19]
      |=> cnt_q[0] == '1)
      else $error("counter wrapped");
   a_cnt_clr_ev: assert property (cnt_clr[1] && cnt_ev[1] // [R15] [R19]
      |=> cnt_q[1] == CNT_W'(1) && rdata[CNT_W-1:0] == $past(cnt_q[1]))
      else $error("counter read lost an event");
   a_cnt_clr_rx: assert property (cnt_clr[0] // [R14] [R19]
      |=> cnt_q[0] == CNT_W'($past(cnt_ev[0]))
          && rdata[CNT_W-1:0] == $past(cnt_q[0]))
      else $error("receive error counter read wrong");
   a_cnt_step: assert property (cnt_ev[0] && !cnt_clr[0] && cnt_q[0] != '1 // [R14]
      |=> cnt_q[0] == $past(cnt_q[0]) + 1'b1)
      else $error("counter did not step");
   a_aux_write: assert property (wr_hs && wr_sel == IDX_ACS && ws[1] // [R16] [R17]
      |=> {ctrl_o.jabber_off, ctrl_o.link_test_off} == $past(wd[15:14]))
      else $error("jabber or link test bit wrong");
   a_squelch_ok: assert property (ctrl_o.squelch_select != SQ_BANNED) // [R18]
      else $error("banned squelch code stored");

   // Bus answer timing and refusals
   a_resp_two: assert property (awvalid && wvalid && !awready && !bvalid
      |-> ##[1:2] bvalid)
      else $error("write answer late");
   a_rd_answer: assert property (arvalid && !arready && !rvalid
      |-> ##[1:2] rvalid)
      else $error("read answer late");
   a_wr_busy: assert property (bvalid |-> !awready && !wready)
      else $error("write taken while response pending");

   c_write_ctrl: cover property (wr_hs && wr_sel == IDX_CTL);
   c_clear_race: cover property (clr_stat && err_i != '0);
   c_cnt_full:   cover property (cnt_q[1] == '1 && cnt_ev[1]);
   c_cnt_race:   cover property (cnt_clr[0] && cnt_ev[0]);
   c_bad_addr:   cover property (rd_hs && rd_sel == IDX_NONE);

endmodule // pacs_regs
`default_nettype wire

// File: verif/pacs_line_model.sv
// Line-side partner model: error events, live levels and partner page
`timescale 1ns/1ps
`default_nettype none
module pacs_line_model
   import pacs_pkg::*;
(
   input  wire logic        aclk,
   input  wire pacs_err_t   ev,
   input  wire logic        rx_pkt,
   input  wire logic        fc_evt,
   input  wire logic [3:0]  lvl,
   input  wire logic [15:0] page,
   output var  pacs_err_t   err_o,
   output var  pacs_line_t  line_o,
   output var  logic [15:0] page_o
);
   ////////////////////////////////////////////////////////////////////////////////
   // Registered, so a request held one cycle is exactly one event pulse
   always_ff @(posedge aclk)
   begin
      err_o  <= ev;
      line_o <= {lvl, rx_pkt, fc_evt};
      page_o <= page;
   end
endmodule // pacs_line_model
`default_nettype wire

// File: verif/tb_top.sv
// Self-checking bench for the auxiliary control/status register bank
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import pacs_pkg::*;
;
   logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic        awready, wready, bvalid, arready, rvalid, rx_pkt, fc_evt;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0]  wstrb, lvl;
   logic [1:0]  bresp, rresp, r;
   logic [15:0] page, page_w, np_w, d;
   pacs_err_t   ev, err_w;
   pacs_line_t  line_w;
   pacs_ctrl_t  ctrl_w;
   int          failures, tests_run;
   logic [15:0] rst_tab [7] = '{NP_RST, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
                                16'h0008};
   int          ctl_bit [4] = '{CT_TXOFF, CT_4B5B, CT_SCR, CT_NRZI};

   ////////////////////////////////////////////////////////////////////////////////
   pacs_regs #(.AW(8), .CNT_W(8)) pacs_regs_i (
      .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
      .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
      .rready, .err_i(err_w), .line_i(line_w), .partner_page_i(page_w),
      .ctrl_o(ctrl_w), .np_page_o(np_w));

   pacs_line_model pacs_line_model_i (
      .aclk, .ev, .rx_pkt, .fc_evt, .lvl, .page,
      .err_o(err_w), .line_o(line_w), .page_o(page_w));

   // Free-running bus clock
   initial
   begin
      aclk = 1'b0;
      forever #25 aclk = ~aclk;
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic final_report();
      $display("compares %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic chk_data(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         failures++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
      chk_data({14'h0000, got}, {14'h0000, exp});
   endtask

   // A wait that ran out is a mismatch and ends the run
   task automatic guard(input int n);
      if (n >= 40)
      begin
         failures++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
         final_report();
      end
   endtask

   function automatic logic [7:0] ad(input logic [3:0] idx);
      return {2'b00, idx, 2'b00};
   endfunction

   // Write: both channels offered together, bready held until bvalid
   task automatic axi_wr(input logic [7:0] a, input logic [15:0] dat, input logic [3:0] s);
      int n;
      @(posedge aclk);
      awaddr <= a;
      wdata <= {16'h0000, dat};
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      n = 0;
      do
      begin
         @(posedge aclk);
         n++;
      end
      while (!(awready === 1'b1 && wready === 1'b1) && n < 40);
      guard(n);
      awvalid <= 1'b0;
      wvalid <= 1'b0;
      n = 0;
      do
      begin
         @(posedge aclk);
         n++;
      end
      while (bvalid !== 1'b1 && n < 40);
      guard(n);
      r = bresp;
      bready <= 1'b0;
   endtask

   // Read, optionally with line events landing on the clearing edge
   task automatic axi_rd(input logic [7:0] a, input pacs_err_t e, input logic [1:0] c);
      int n;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      ev <= e;
      {rx_pkt, fc_evt} <= c;
      @(posedge aclk);
      ev <= '0;
      {rx_pkt, fc_evt} <= 2'b00;
      n = 1;
      while (arready !== 1'b1 && n < 40)
      begin
         @(posedge aclk);
         n++;
      end
      guard(n);
      arvalid <= 1'b0;
      n = 0;
      do
      begin
         @(posedge aclk);
         n++;
      end
      while (rvalid !== 1'b1 && n < 40);
      guard(n);
      d = rdata[15:0];
      r = rresp;
      rready <= 1'b0;
   endtask

   // One event request cycle, then quiet
   task automatic fire(input pacs_err_t e, input logic [1:0] c);
      @(posedge aclk);
      ev <= e;
      {rx_pkt, fc_evt} <= c;
      @(posedge aclk);
      ev <= '0;
      {rx_pkt, fc_evt} <= 2'b00;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence; autonegotiation flag level held high throughout
   initial
   begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready, rx_pkt, fc_evt} = '0;
      {awaddr, araddr, wdata, wstrb, page, ev} = '0;
      lvl = 4'h2;
      failures = 0;
      tests_run = 0;
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      for (int i = 0; i < 7; i++)
      begin
         axi_rd(ad(IDX_NP_TX + 4'(i)), '0, 2'b00);
         chk_data(d, rst_tab[i]);
      end
      chk_data({8'h00, ctrl_w}, 16'h0000);
      $display("test reset_values done");
      // Local page: toggle bit and bit 14 never writable
      axi_wr(ad(IDX_NP_TX), 16'hFFFF, 4'h3);
      axi_rd(ad(IDX_NP_TX), '0, 2'b00);
      chk_data(d, 16'hB7FF);
      chk_data(np_w, 16'hB7FF);
      lvl[0] <= 1'b1;
      axi_wr(ad(IDX_NP_TX), 16'h0000, 4'h3);
      axi_rd(ad(IDX_NP_TX), '0, 2'b00);
      chk_data(d, 16'h0800);
      page <= 16'hFFFF;
      axi_wr(ad(IDX_LP_RX), 16'h0000, 4'h3);
      chk_resp(r, RESP_OKAY);
      axi_rd(ad(IDX_LP_RX), '0, 2'b00);
      chk_data(d, LP_MASK);
      chk_resp(r, RESP_OKAY);
      $display("test next_page done");
      // Each datapath control bit alone, then all, then a lane-0-only write
      for (int k = 0; k < 4; k++)
      begin
         axi_wr(ad(IDX_CTL), 16'h0001 << ctl_bit[k], 4'h3);
         axi_rd(ad(IDX_CTL), '0, 2'b00);
         chk_data(d, 16'h0001 << ctl_bit[k]);
         chk_data({8'h00, ctrl_w}, 16'h0080 >> k);
      end
      axi_wr(ad(IDX_CTL), 16'h2700, 4'h3);
      axi_wr(ad(IDX_CTL), 16'h0000, 4'h1);
      axi_rd(ad(IDX_CTL), '0, 2'b00);
      chk_data(d, 16'h2700);
      chk_data({8'h00, ctrl_w}, 16'h00F0);
      // Jabber, link test and the three legal squelch modes
      for (int k = 0; k < 3; k++)
      begin
         axi_wr(ad(IDX_ACS), 16'hC000 | 16'(k << AC_SQ), 4'h3);
         axi_rd(ad(IDX_ACS), '0, 2'b00);
         chk_data(d, 16'hC008 | 16'(k << AC_SQ));
         // Datapath bits from the previous test are still set
         chk_data({8'h00, ctrl_w}, 16'h00FC | 16'(k));
      end
      $display("test controls done");
      // Sticky bits one by one, live bits beside them
      lvl <= 4'hE;
      for (int k = 0; k < 6; k++)
      begin
         fire(pacs_err_t'(6'h01 << k), 2'b00);
         axi_rd(ad(IDX_STAT), '0, 2'b00);
         chk_data(d, 16'h0300 | 16'(1 << k));
         axi_rd(ad(IDX_STAT), '0, 2'b00);
         chk_data(d, 16'h0300);
      end
      // Events on the clearing edge survive to the next read
      axi_rd(ad(IDX_STAT), 6'h3F, 2'b00);
      chk_data(d, 16'h0300);
      axi_rd(ad(IDX_STAT), '0, 2'b00);
      chk_data(d, 16'h033F);
      $display("test status done");
      // Both counters: small count, coincident read, saturation
      for (int c = 0; c < 2; c++)
      begin
         repeat (3) fire('0, c ? 2'b01 : 2'b10);
         axi_rd(c ? ad(IDX_FCC) : ad(IDX_RXEC), '0, 2'b00);
         chk_data(d, 16'h0003);
         axi_rd(c ? ad(IDX_FCC) : ad(IDX_RXEC), '0, c ? 2'b01 : 2'b10);
         chk_data(d, 16'h0000);
         axi_rd(c ? ad(IDX_FCC) : ad(IDX_RXEC), '0, 2'b00);
         chk_data(d, 16'h0001);
         repeat (260) fire('0, c ? 2'b01 : 2'b10);
         axi_rd(c ? ad(IDX_FCC) : ad(IDX_RXEC), '0, 2'b00);
         chk_data(d, 16'h00FF);
         axi_rd(c ? ad(IDX_FCC) : ad(IDX_RXEC), '0, 2'b00);
         chk_data(d, 16'h0000);
      end
      $display("test counters done");
      // Unmapped and misaligned places answer with an error
      axi_rd(ad(IDX_NONE), '0, 2'b00);
      chk_resp(r, RESP_SLV);
      chk_data(d, 16'h0000);
      axi_wr(8'h1D, 16'h0000, 4'h3);
      chk_resp(r, RESP_SLV);
      $display("test unmapped done");
      final_report();
   end
endmodule // tb_top
`default_nettype wire
